// *** design/dsps_pkg.sv ***
// dsps_pkg: constants for the per-channel sync select and power readback slice
package dsps_pkg;

  // ***********************************************
  // bus and page layout
  // ***********************************************
  localparam int unsigned AW        = 18;       // byte address width
  localparam int unsigned CHAN_W    = 3;        // channel number width
  localparam logic [CHAN_W-1:0] CHAN_DEFAULT = 3'h0;
  // page digit is 2*channel+1; config page low nibble 0, results page 2
  localparam logic [3:0] PAGE_CFG_LO = 4'h0;
  localparam logic [3:0] PAGE_RES_LO = 4'h2;
  localparam int unsigned PAGE_LSB  = 8;        // index bits [15:8] hold page
  localparam int unsigned IDX_W     = 8;        // in-page index width

  // register indices (byte address is four times the page index)
  localparam logic [IDX_W-1:0] IDX_SYNC_SEL = 8'h1D;
  localparam logic [IDX_W-1:0] IDX_CHKSUM   = 8'h00;
  localparam logic [IDX_W-1:0] IDX_PA_LO    = 8'h01;
  localparam logic [IDX_W-1:0] IDX_PA_MID   = 8'h02;
  localparam logic [IDX_W-1:0] IDX_PA_UP    = 8'h03;
  localparam logic [IDX_W-1:0] IDX_PB_LO    = 8'h04;
  localparam logic [IDX_W-1:0] IDX_PB_MID   = 8'h05;
  localparam logic [IDX_W-1:0] IDX_PB_UP    = 8'h06;
  localparam logic [IDX_W-1:0] IDX_PAB_TOP  = 8'h07;

  // ***********************************************
  // sync select field layout
  // ***********************************************
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned NCO_LSB     = 12;
  localparam int unsigned DITHER_LSB  = 8;
  localparam int unsigned FREQ_LSB    = 4;
  localparam int unsigned PHASE_LSB   = 0;
  localparam logic [15:0] SYNC_SEL_RST  = 16'h0000;
  localparam logic [15:0] SYNC_SEL_MASK = 16'h7777;

  // sync source encodings
  localparam logic [SEL_W-1:0] SRC_EXT_D    = 3'h3;
  localparam logic [SEL_W-1:0] SRC_COUNTER  = 3'h4;
  localparam logic [SEL_W-1:0] SRC_ONESHOT  = 3'h5;
  localparam logic [SEL_W-1:0] SRC_ZERO     = 3'h6;
  localparam logic [SEL_W-1:0] SRC_ONE      = 3'h7;

  // ***********************************************
  // power result layout
  // ***********************************************
  localparam int unsigned PWR_W     = 55;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned TOP_W     = 7;
  localparam int unsigned TOPA_LSB  = 9;
  localparam int unsigned TOPB_LSB  = 1;
  localparam logic [15:0] RES_RST   = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // slave state
  typedef enum logic [1:0] {
    DSPS_IDLE = 2'b00,
    DSPS_WRSP = 2'b01,
    DSPS_RRSP = 2'b11
  } dsps_state_e;

endpackage : dsps_pkg

// *** design/dsps_sync_if.sv ***
// dsps_sync_if: carries one selector and the sync sources to its decoder
`timescale 1ns/10ps
`default_nettype none
interface dsps_sync_if;
  import dsps_pkg::*;
  logic [SEL_W-1:0] sel;        // selector code
  logic [3:0]       ext_sync;   // external syncs a..d
  logic             cnt_sync;   // channel sync counter
  logic             one_shot;   // write triggered pulse
  logic             event_out;  // single-cycle event
  modport ctrl (output sel, ext_sync, cnt_sync, one_shot, input event_out);
  modport dec  (input sel, ext_sync, cnt_sync, one_shot, output event_out);
endinterface : dsps_sync_if
`default_nettype wire

// *** design/dsps_sync_decode.sv ***
// dsps_sync_decode: decodes one sync selector into a single-cycle event
`timescale 1ns/10ps
`default_nettype none
module dsps_sync_decode
  import dsps_pkg::*;
(
  input  wire logic clk_sys_in,  // system clock
  input  wire logic arst_n_in,   // async reset, active low
  dsps_sync_if.dec  sif          // selector and sources
);

  logic level_next;
  logic level_reg;
  logic prev_reg;
  logic prev_next;

  // choose the sync source level
  always_comb begin
    unique case (sif.sel)
      SRC_COUNTER: level_next = sif.cnt_sync;   // R13
      SRC_ONESHOT: level_next = sif.one_shot;   // R13
      SRC_ZERO:    level_next = 1'b0;           // R13
      SRC_ONE:     level_next = 1'b1;           // R13
      default:     level_next = sif.ext_sync[sif.sel[1:0]]; // R13
    endcase
    prev_next = level_reg;
  end

  // register level so a held source yields one event, not many
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      level_reg <= level_next;
      prev_reg  <= prev_next;
    end
  end

  // rising edge gives a one-cycle event; constant one fires once
  assign sif.event_out = level_reg & ~prev_reg; // R15

endmodule : dsps_sync_decode
`default_nettype wire

// *** design/dsps_regs.sv ***
// dsps_regs: sync select register and power readback over axi4-lite
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: field selects sync source for phase accumulator reset, bits 14:12.
// R2: field selects sync source for dither generator reset, bits 10:8.
// R3: field selects sync source loading frequency register, bits 6:4.
// R4: field selects sync source loading phase offset register, bits 2:0.
// R5: checksum read only at results index 0x00, zero after reset; the code passes checksum_in through live and does not reset it.
// R6: power A bits 15:0 at results index 0x01.
// R7: power A bits 31:16 at results index 0x02.
// R8: power A bits 47:32 at results index 0x03.
// R9: power B bits 15:0 at results index 0x04.
// R10: power B bits 31:16 at results index 0x05.
// R11: power B bits 47:32 at results index 0x06.
// R12: each channel has own copy; page digit is twice channel plus one.
// R13: codes 0-3 external syncs, 4 counter, 5 one-shot, 6 zero, 7 one.
// R14: power is 55 bits; top 7 bits of each stream at index 0x07.
// R15: selected sync is one-cycle event; writes to results are ignored.
module dsps_regs
  import dsps_pkg::*;
#(
  parameter logic [CHAN_W-1:0] CHANNEL = CHAN_DEFAULT  // channel number
) (
  input  wire logic              clk_sys_in,     // system clock
  input  wire logic              arst_n_in,      // async reset, active low
  input  wire logic [AW-1:0]     s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // write strobes
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [AW-1:0]     s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire logic [3:0]        ext_sync_in,    // external syncs a..d
  input  wire logic              sync_count_in,  // channel sync counter
  input  wire logic [WORD_W-1:0] checksum_in,    // self-test checksum
  input  wire logic [PWR_W-1:0]  power_a_in,     // stream A power
  input  wire logic [PWR_W-1:0]  power_b_in,     // stream B power
  output logic                   acc_reset_out,  // phase accumulator reset
  output logic                   dither_rst_out, // dither generator reset
  output logic                   freq_load_out,  // frequency register load
  output logic                   phase_load_out  // phase offset load
);

  // ***********************************************
  // page decode
  // ***********************************************
  // page digit is 2*channel+1 in the high nibble of the page byte
  localparam logic [3:0] PAGE_DIGIT = 4'({CHANNEL, 1'b1});           // R12
  localparam logic [7:0] PAGE_CFG   = {PAGE_DIGIT, PAGE_CFG_LO};      // R12
  localparam logic [7:0] PAGE_RES   = {PAGE_DIGIT, PAGE_RES_LO};      // R12
  localparam int unsigned NSYNC     = 4;

  dsps_state_e      state_reg;
  dsps_state_e      state_next;
  logic [AW-1:0]    awaddr_reg;
  logic [AW-1:0]    awaddr_next;
  logic             aw_got_reg;
  logic             aw_got_next;
  logic [31:0]      wdata_reg;
  logic [31:0]      wdata_next;
  logic [3:0]       wstrb_reg;
  logic [3:0]       wstrb_next;
  logic             w_got_reg;
  logic             w_got_next;
  logic [1:0]       bresp_reg;
  logic [1:0]       bresp_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [1:0]       rresp_reg;
  logic [1:0]       rresp_next;
  logic [15:0]      sync_sel_reg;
  logic [15:0]      sync_sel_next;
  logic             shot_reg;
  logic             shot_next;
  logic [WORD_W-1:0] res_rd;
  logic             res_hit;

  // split a byte address into page and index
  function automatic logic [15:0] page_index(input logic [AW-1:0] a);
    logic [15:0] w;
    w = 16'(a >> 2);
    return w;
  endfunction : page_index

  // ***********************************************
  // write channel and register update
  // ***********************************************
  // aw and w accepted in either order, held until both are in
  always_comb begin
    logic [15:0] pi;
    logic [15:0] wv;
    pi            = page_index(awaddr_reg);
    wv            = sync_sel_reg;
    state_next    = state_reg;
    awaddr_next   = awaddr_reg;
    aw_got_next   = aw_got_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    w_got_next    = w_got_reg;
    bresp_next    = bresp_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    sync_sel_next = sync_sel_reg;
    shot_next     = 1'b0;
    case (state_reg)
      DSPS_IDLE: begin
        if (s_axi_awvalid && !aw_got_reg) begin
          awaddr_next = s_axi_awaddr;
          aw_got_next = 1'b1;
        end
        if (s_axi_wvalid && !w_got_reg) begin
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
          w_got_next = 1'b1;
        end
        if (aw_got_reg && w_got_reg) begin
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
          state_next  = DSPS_WRSP;
          bresp_next  = RESP_SLVERR;
          if (pi[15:PAGE_LSB] == PAGE_CFG && pi[IDX_W-1:0] == IDX_SYNC_SEL) begin
            if (wstrb_reg[0]) wv[7:0]  = wdata_reg[7:0];
            if (wstrb_reg[1]) wv[15:8] = wdata_reg[15:8];
            sync_sel_next = wv & SYNC_SEL_MASK;  // R1 R2 R3 R4
            shot_next     = 1'b1;   // any write here fires the one-shot
            bresp_next    = RESP_OKAY;
          end else if (pi[15:PAGE_LSB] == PAGE_RES && pi[IDX_W-1:0] <= IDX_PAB_TOP) begin
            bresp_next = RESP_OKAY; // R15
          end
        end else if (s_axi_arvalid && !aw_got_reg && !w_got_reg) begin
          // reads wait while a write is half taken, so order is kept
          state_next = DSPS_RRSP;
          pi         = page_index(s_axi_araddr);
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
          if (pi[15:PAGE_LSB] == PAGE_CFG && pi[IDX_W-1:0] == IDX_SYNC_SEL) begin
            rdata_next = {16'h0000, sync_sel_reg};
            rresp_next = RESP_OKAY;
          end else if (pi[15:PAGE_LSB] == PAGE_RES && res_hit) begin
            rdata_next = {16'h0000, res_rd};
            rresp_next = RESP_OKAY;
          end
        end
      end
      DSPS_WRSP: begin
        if (s_axi_bready) state_next = DSPS_IDLE;
      end
      DSPS_RRSP: begin
        if (s_axi_rready) state_next = DSPS_IDLE;
      end
      default: state_next = DSPS_IDLE;
    endcase
  end

  // ***********************************************
  // result read mux
  // ***********************************************
  // results read live; the datapath holds them stable between updates
  always_comb begin
    logic [7:0] ri;
    ri      = IDX_W'(page_index(s_axi_araddr));
    res_hit = 1'b1;
    res_rd  = RES_RST;
    case (ri)
      IDX_CHKSUM: res_rd = checksum_in;                      // R5
      IDX_PA_LO:  res_rd = power_a_in[15:0];                 // R6
      IDX_PA_MID: res_rd = power_a_in[31:16];                // R7
      IDX_PA_UP:  res_rd = power_a_in[47:32];                // R8
      IDX_PB_LO:  res_rd = power_b_in[15:0];                 // R9
      IDX_PB_MID: res_rd = power_b_in[31:16];                // R10
      IDX_PB_UP:  res_rd = power_b_in[47:32];                // R11
      IDX_PAB_TOP: begin
        res_rd[TOPA_LSB +: TOP_W] = power_a_in[PWR_W-1 -: TOP_W]; // R14
        res_rd[TOPB_LSB +: TOP_W] = power_b_in[PWR_W-1 -: TOP_W]; // R14
      end
      default: res_hit = 1'b0;
    endcase
  end

  // state registers only
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg    <= DSPS_IDLE;
      awaddr_reg   <= '0;
      aw_got_reg   <= 1'b0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      w_got_reg    <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= RESP_OKAY;
      sync_sel_reg <= SYNC_SEL_RST;
      shot_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      awaddr_reg   <= awaddr_next;
      aw_got_reg   <= aw_got_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      w_got_reg    <= w_got_next;
      bresp_reg    <= bresp_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      sync_sel_reg <= sync_sel_next;
      shot_reg     <= shot_next;
    end
  end

  // handshake outputs
  assign s_axi_awready = (state_reg == DSPS_IDLE) && !aw_got_reg;
  assign s_axi_wready  = (state_reg == DSPS_IDLE) && !w_got_reg;
  assign s_axi_arready = (state_reg == DSPS_IDLE) && !aw_got_reg
                         && !w_got_reg;
  assign s_axi_bvalid  = (state_reg == DSPS_WRSP);
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = (state_reg == DSPS_RRSP);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ***********************************************
  // sync decoders
  // ***********************************************
  logic [NSYNC-1:0] evt;
  localparam int unsigned LSBS [NSYNC] = '{NCO_LSB, DITHER_LSB,
                                           FREQ_LSB, PHASE_LSB};

  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    dsps_sync_if sif ();
    assign sif.sel      = sync_sel_reg[LSBS[g] +: SEL_W]; // R1 R2 R3 R4
    assign sif.ext_sync = ext_sync_in;
    assign sif.cnt_sync = sync_count_in; // R13
    assign sif.one_shot = shot_reg;
    assign evt[g]       = sif.event_out;
    dsps_sync_decode u_dec (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .sif        (sif)
    );
  end

  assign acc_reset_out  = evt[0]; // R1
  assign dither_rst_out = evt[1]; // R2
  assign freq_load_out  = evt[2]; // R3
  assign phase_load_out = evt[3]; // R4

endmodule : dsps_regs
`default_nettype wire

// *** tb/dsps_regs_checker.sv ***
// dsps_regs_checker: port-level assertions on the register slice
`timescale 1ns/10ps
`default_nettype none
module dsps_regs_checker
  import dsps_pkg::*;
(
  input wire logic        clk_sys_in,     // clock
  input wire logic        arst_n_in,      // reset
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic [1:0]  s_axi_bresp,    // b resp
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_bready,   // b ready
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // r data
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        s_axi_rready,   // r ready
  input wire logic        acc_reset_out,  // acc reset
  input wire logic        dither_rst_out, // dither reset
  input wire logic        freq_load_out,  // freq load
  input wire logic        phase_load_out  // phase load
);
  // *******************************
  // assertions, one clock domain
  // *******************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // answers must stand until the host takes them
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("late read");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("bad write timing");
  // a pending answer blocks new address phases
  a_busy_blocks: assert property (s_axi_bvalid || s_axi_rvalid
    |-> !s_axi_arready && !s_axi_awready) else $error("overlap");
  // events are single-cycle, never stretched by a held source
  a_acc_single: assert property (
    acc_reset_out |=> !acc_reset_out) else $error("acc pulse long");
  a_dither_single: assert property (
    dither_rst_out |=> !dither_rst_out) else $error("dither long");
  a_freq_single: assert property (
    freq_load_out |=> !freq_load_out) else $error("freq pulse long");
  a_phase_single: assert property (
    phase_load_out |=> !phase_load_out) else $error("phase long");
endmodule : dsps_regs_checker
bind dsps_regs dsps_regs_checker chk_u (.clk_sys_in, .arst_n_in,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .acc_reset_out, .dither_rst_out, .freq_load_out, .phase_load_out);
`default_nettype wire

// *** tb/dsps_host_model.sv ***
// dsps_host_model: axi4-lite host that reaches the channel registers
`timescale 1ns/10ps
`default_nettype none
module dsps_host_model
  import dsps_pkg::*;
(
  input  wire logic          clk_sys_in, // clock
  output logic [AW-1:0]      awaddr,     // aw addr
  output logic               awvalid,    // aw valid
  input  wire logic          awready,    // aw ready
  output logic [31:0]        wdata,      // w data
  output logic [3:0]         wstrb,      // w strobes
  output logic               wvalid,     // w valid
  input  wire logic          wready,     // w ready
  input  wire logic [1:0]    bresp,      // b resp
  input  wire logic          bvalid,     // b valid
  output logic               bready,     // b ready
  output logic [AW-1:0]      araddr,     // ar addr
  output logic               arvalid,    // ar valid
  input  wire logic          arready,    // ar ready
  input  wire logic [31:0]   rdata,      // r data
  input  wire logic [1:0]    rresp,      // r resp
  input  wire logic          rvalid,     // r valid
  output logic               rready      // r ready
);
  int rdy_dly = 0; // cycles a slow host waits before taking answers
  logic [3:0] wr_strb = 4'hF; // byte lanes used by the next write
  // ***********************
  // bus cycles
  // ***********************
  // idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // address keeps only the low bits the slave decodes
  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk_sys_in);
    awaddr  <= AW'({idx, 2'b00});
    wdata   <= {16'h0000, d};
    wstrb   <= wr_strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (rdy_dly == 0);
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (i + 1 >= rdy_dly) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 200) begin
      tb.n_fail++;
      tb.give_verdict();
    end
  endtask : wr
  task automatic rd(input logic [15:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk_sys_in);
    araddr  <= AW'({idx, 2'b00});
    arvalid <= 1'b1;
    rready  <= (rdy_dly == 0);
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (i + 1 >= rdy_dly) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 200) begin
      tb.n_fail++;
      tb.give_verdict();
    end
  endtask : rd
endmodule : dsps_host_model
`default_nettype wire

// *** tb/tb.sv ***
// tb: self-checking bench for the sync select and power readback slice
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dsps_pkg::*;
  // ***********************
  // signals and checks
  // ***********************
  localparam logic [CHAN_W-1:0] CH = 3'h2;
  localparam logic [7:0] CPG = {4'(2 * CH + 1), PAGE_CFG_LO};
  localparam logic [7:0] RPG = {4'(2 * CH + 1), PAGE_RES_LO};
  localparam logic [15:0] SEL = {CPG, IDX_SYNC_SEL};
  logic clk_sys_in, arst_n_in, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [AW-1:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [3:0] ws, ext, ev;
  logic [1:0] bresp, rresp;
  logic cnt;
  logic [15:0] sum;
  logic [PWR_W-1:0] pa, pb;
  int n_pulse[4];
  int n_fail, cmp_count;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); end end
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // count event pulses; a scenario looks at differences only
  always @(posedge clk_sys_in) begin
    for (int i = 0; i < 4; i++) if (ev[i] === 1'b1) n_pulse[i]++;
  end
  dsps_regs #(.CHANNEL(CH)) dut_u (.clk_sys_in, .arst_n_in,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_sync_in(ext),
    .sync_count_in(cnt), .checksum_in(sum), .power_a_in(pa),
    .power_b_in(pb), .acc_reset_out(ev[0]), .dither_rst_out(ev[1]),
    .freq_load_out(ev[2]), .phase_load_out(ev[3]));
  dsps_host_model host_u (.clk_sys_in, .awaddr(awa), .awvalid(awv),
    .awready(awr), .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr_r),
    .bresp, .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
    .arready(arr), .rdata(rd_d), .rresp, .rvalid(rv), .rready(rr));
  // ***********************
  // scenarios
  // ***********************
  task automatic wr(input logic [15:0] i, d, input logic [1:0] er);
    logic [1:0] r;
    host_u.wr(i, d, r);
    `CHK(r, er)
  endtask : wr
  task automatic rchk(input logic [15:0] i, e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(i, d, r);
    `CHK(d, {16'h0000, e})
    `CHK(r, er)
  endtask : rchk
  // reset values, then reserved selector bits stay zero
  task automatic t_select();
    rchk(SEL, SYNC_SEL_RST, RESP_OKAY);
    rchk({RPG, IDX_CHKSUM}, 16'h0000, RESP_OKAY);
    wr(SEL, 16'hFFFF, RESP_OKAY);
    rchk(SEL, 16'h7777, RESP_OKAY);
    wr(SEL, 16'h5A3C, RESP_OKAY);
    rchk(SEL, 16'h5234, RESP_OKAY);
    // upper byte lane only: the low byte fields must keep their codes
    host_u.wr_strb = 4'h2;
    wr(SEL, 16'h0000, RESP_OKAY);
    rchk(SEL, 16'h0034, RESP_OKAY);
    host_u.wr_strb = 4'hF;
  endtask : t_select
  // live results, a slow host, ignored writes, an unmapped place
  task automatic t_results();
    @(posedge clk_sys_in);
    sum <= 16'hA5C3;
    pa  <= {7'h5B, 48'h1234_5678_9ABC};
    pb  <= {7'h2D, 48'hFEDC_BA98_7654};
    rchk({RPG, IDX_CHKSUM}, 16'hA5C3, RESP_OKAY);
    rchk({RPG, IDX_PA_LO}, 16'h9ABC, RESP_OKAY);
    rchk({RPG, IDX_PA_MID}, 16'h5678, RESP_OKAY);
    host_u.rdy_dly = 3;
    rchk({RPG, IDX_PA_UP}, 16'h1234, RESP_OKAY);
    rchk({RPG, IDX_PB_LO}, 16'h7654, RESP_OKAY);
    wr({RPG, IDX_PB_LO}, 16'h0F0F, RESP_OKAY);
    host_u.rdy_dly = 0;
    rchk({RPG, IDX_PB_LO}, 16'h7654, RESP_OKAY);
    rchk({RPG, IDX_PB_MID}, 16'hBA98, RESP_OKAY);
    rchk({RPG, IDX_PB_UP}, 16'hFEDC, RESP_OKAY);
    rchk({RPG, IDX_PAB_TOP}, 16'hB65A, RESP_OKAY);
    rchk({RPG, 8'h08}, 16'h0000, RESP_SLVERR);
    // channel zero's results page belongs to another copy
    rchk({4'h1, PAGE_RES_LO, IDX_CHKSUM}, 16'h0000, RESP_SLVERR);
  endtask : t_results
  // every code on every selector: quiet on others, one pulse on its own
  task automatic t_sync();
    int b, lsb;
    for (int f = 0; f < 4; f++) begin
      lsb = 12 - 4 * f;
      for (int c = 0; c < 8; c++) begin
        @(posedge clk_sys_in);
        {cnt, ext} <= 5'h00;
        b = n_pulse[f];
        wr(SEL, (16'h6666 & ~(16'h7 << lsb)) | (16'(c) << lsb),
           RESP_OKAY);
        repeat (6) @(posedge clk_sys_in);
        `CHK(n_pulse[f] - b, (c == 5 || c == 7) ? 1 : 0)
        if (c < 5) begin
          {cnt, ext} <= 5'h1F ^ (5'h01 << c);
          repeat (6) @(posedge clk_sys_in);
          `CHK(n_pulse[f] - b, 0)
          {cnt, ext} <= 5'h1F;
          repeat (6) @(posedge clk_sys_in);
          `CHK(n_pulse[f] - b, 1)
        end
      end
    end
  endtask : t_sync
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    arst_n_in = 1'b0;
    {cnt, ext, sum, pa, pb} = '0;
    {n_fail, cmp_count} = '0;
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_select();
    t_results();
    t_sync();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
